// ### common/wdt_if.sv
// Link between the power-mode controller and the watchdog counter.
interface wdt_if;
  logic run;
  logic restart;
  logic [2:0] sel;
  logic expire;
  modport ctrl (output run, output restart, output sel, input expire);
  modport cnt (input run, input restart, input sel, output expire);
endinterface

// ### common/wdt_pkg.sv
// Constants, field layouts and types shared by the watchdog and power-down control block.
package wdt_pkg;
  localparam int APB_ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EVENT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;

  localparam int CTRL_W = 8;
  localparam int HALT_RUN_BIT = 7;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 4;
  localparam int STOP_DIS_BIT = 3;
  localparam int LOCK_LO = 3;
  localparam logic [7:0] CTRL_RESET = 8'hF8;
  localparam logic [7:0] CTRL_WR_MASK = 8'hF8;

  localparam int EV_W = 3;
  localparam int EV_WDT = 0;
  localparam int EV_SMR = 1;
  localparam int EV_HALT_EXIT = 2;
  localparam logic [2:0] EV_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  localparam logic [1:0] CAUSE_PIN = 2'h0;
  localparam logic [1:0] CAUSE_SMR = 2'h1;
  localparam logic [1:0] CAUSE_WDT = 2'h2;

  localparam logic [7:0] OP_HALT = 8'h7F;
  localparam logic [7:0] OP_STOP_DEFAULT = 8'h6F;
  localparam logic [7:0] OP_REFRESH_DEFAULT = 8'h5F;
  localparam logic [15:0] RESET_VECTOR = 16'h0020;

  // Shortest timeout in crystal cycles; each select step doubles it.
  localparam int WDT_BASE_CYCLES = 65536;
  localparam int CNT_W = 23;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_HALT = 3'b010,
    MODE_STOP = 3'b100
  } mode_t;
endpackage

// ### core/wdt_counter.sv
// Watchdog counter with a selectable power-of-two timeout.
module wdt_counter #(
  parameter int BASE_CYCLES = wdt_pkg::WDT_BASE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  wdt_if.cnt wd
);
  typedef struct packed {
    logic [wdt_pkg::CNT_W-1:0] count;
    logic expire;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  function automatic logic [wdt_pkg::CNT_W-1:0] limitOf(input logic [2:0] sel);
    logic [wdt_pkg::CNT_W-1:0] base;
    base = wdt_pkg::CNT_W'(BASE_CYCLES);
    limitOf = base << (3'(sel - 3'h1));
  endfunction

  always_comb
  begin
    state_next = state_reg;
    state_next.expire = 1'b0;
    if (wd.restart)
    begin
      state_next.count = '0;
    end
    else if (wd.run && wd.sel != 3'h0)
    begin
      if (state_reg.count >= limitOf(wd.sel) - 1'b1)
      begin
        state_next.count = '0;
        state_next.expire = 1'b1;
      end
      else
      begin
        state_next.count = state_reg.count + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign wd.expire = state_reg.expire;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_expire_at_limit: assert property (wd.expire |-> $past(state_reg.count) == limitOf($past(wd.sel)) - 1'b1)
    else $error("Watchdog expired away from the selected limit.");
  a_disabled_silent: assert property (wd.sel == 3'h0 && !wd.restart |=> !wd.expire && $stable(state_reg.count))
    else $error("Disabled watchdog still counted.");
  a_restart_clears: assert property (wd.restart |=> state_reg.count == '0 && !wd.expire)
    else $error("Refresh did not restart the count.");
endmodule

// ### core/wdt_power_ctrl.sv
// Watchdog and power-down mode controller with an APB register slave.
module wdt_power_ctrl #(
  parameter int BASE_CYCLES = wdt_pkg::WDT_BASE_CYCLES,
  parameter logic [7:0] OP_STOP = wdt_pkg::OP_STOP_DEFAULT,
  parameter logic [7:0] OP_REFRESH = wdt_pkg::OP_REFRESH_DEFAULT
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdt_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instrValid,
  input wire logic [7:0] opcode,
  input wire logic irqService,
  input wire logic smrWake,
  output logic cpuClkEn,
  output logic oscEn,
  output logic sysRst,
  output logic [1:0] resetCause,
  output logic pcLoad,
  output logic [15:0] restartPc,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] events;
    logic [2:0] mask;
    wdt_pkg::mode_t mode;
    logic firstPending;
    logic sysRst;
    logic [1:0] cause;
    logic pcLoad;
    logic [15:0] pc;
    logic [31:0] rdata;
  } ctrl_state_t;

  localparam ctrl_state_t STATE_RESET = '{
    ctrl: wdt_pkg::CTRL_RESET,
    events: wdt_pkg::EV_RESET,
    mask: wdt_pkg::MASK_RESET,
    mode: wdt_pkg::MODE_RUN,
    firstPending: 1'b1,
    sysRst: 1'b1,
    cause: wdt_pkg::CAUSE_PIN,
    pcLoad: 1'b0,
    pc: wdt_pkg::RESET_VECTOR,
    rdata: 32'h0000_0000
  };

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  wdt_if wd ();

  wdt_counter #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_counter (
    .mclk(mclk),
    .srst(srst),
    .wd(wd)
  );

  function automatic logic isMapped(input logic [wdt_pkg::APB_ADDR_W-1:0] a);
    isMapped = (a == wdt_pkg::ADDR_CTRL) || (a == wdt_pkg::ADDR_EVENT) ||
               (a == wdt_pkg::ADDR_MASK) || (a == wdt_pkg::ADDR_STATE);
  endfunction

  logic setupRead;
  logic wrAccess;
  logic wrCtrl;
  logic wrEvent;
  logic runCycle;
  logic haltOp;
  logic stopOp;
  logic refreshOp;
  logic wakeNow;

  assign setupRead = psel && !penable && !pwrite;
  assign wrAccess = psel && penable && pwrite;
  assign wrCtrl = wrAccess && paddr == wdt_pkg::ADDR_CTRL;
  assign wrEvent = wrAccess && paddr == wdt_pkg::ADDR_EVENT;
  assign runCycle = instrValid && state_reg.mode == wdt_pkg::MODE_RUN;
  assign haltOp = runCycle && opcode == wdt_pkg::OP_HALT;
  assign stopOp = runCycle && opcode == OP_STOP;
  assign refreshOp = runCycle && opcode == OP_REFRESH;
  assign wakeNow = state_reg.mode == wdt_pkg::MODE_STOP && smrWake;

  // The counter runs in RUN, and in HALT only when bit 7 allows; the oscillator is off in STOP.
  assign wd.run = state_reg.mode == wdt_pkg::MODE_RUN ||
                  (state_reg.mode == wdt_pkg::MODE_HALT && state_reg.ctrl[wdt_pkg::HALT_RUN_BIT]);
  assign wd.sel = state_reg.ctrl[wdt_pkg::SEL_HI:wdt_pkg::SEL_LO];
  assign wd.restart = refreshOp || wakeNow || wd.expire;

  always_comb
  begin
    state_next = state_reg;
    state_next.sysRst = 1'b0;
    state_next.pcLoad = 1'b0;
    if (setupRead)
    begin
      // Read data is sampled in the setup cycle so that it leaves a flip-flop in the access cycle.
      case (paddr)
        wdt_pkg::ADDR_CTRL: state_next.rdata = {24'h00_0000, state_reg.ctrl};
        wdt_pkg::ADDR_EVENT: state_next.rdata = {29'h0000_0000, state_reg.events};
        wdt_pkg::ADDR_MASK: state_next.rdata = {29'h0000_0000, state_reg.mask};
        wdt_pkg::ADDR_STATE: state_next.rdata = {24'h00_0000, state_reg.cause, state_reg.firstPending,
                                                 2'h0, state_reg.mode};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
    // Writes land first so that hardware events below win over a same-cycle clear.
    if (wrCtrl && state_reg.firstPending)
    begin
      state_next.ctrl = pwdata[7:0] & wdt_pkg::CTRL_WR_MASK;
    end
    if (wrEvent)
    begin
      state_next.events = state_reg.events & ~pwdata[2:0];
    end
    if (wrAccess && paddr == wdt_pkg::ADDR_MASK)
    begin
      state_next.mask = pwdata[2:0];
    end
    if (runCycle)
    begin
      state_next.firstPending = 1'b0;
    end
    case (state_reg.mode)
      wdt_pkg::MODE_RUN:
      begin
        if (haltOp)
        begin
          state_next.mode = wdt_pkg::MODE_HALT;
        end
        else if (stopOp && !state_reg.ctrl[wdt_pkg::STOP_DIS_BIT])
        begin
          state_next.mode = wdt_pkg::MODE_STOP;
        end
      end
      wdt_pkg::MODE_HALT:
      begin
        if (irqService)
        begin
          state_next.mode = wdt_pkg::MODE_RUN;
          state_next.events[wdt_pkg::EV_HALT_EXIT] = 1'b1;
        end
      end
      wdt_pkg::MODE_STOP:
      begin
        if (smrWake)
        begin
          state_next.mode = wdt_pkg::MODE_RUN;
          state_next.ctrl[wdt_pkg::STOP_DIS_BIT] = 1'b1;
          state_next.events[wdt_pkg::EV_SMR] = 1'b1;
          state_next.sysRst = 1'b1;
          state_next.cause = wdt_pkg::CAUSE_SMR;
          state_next.pcLoad = 1'b1;
          state_next.firstPending = 1'b1;
        end
      end
      default: state_next.mode = wdt_pkg::MODE_RUN;
    endcase
    // A timeout keeps the control bits; the pin reset restores them all, and a Stop wakeup restores bit 3.
    if (wd.expire)
    begin
      state_next.mode = wdt_pkg::MODE_RUN;
      state_next.events[wdt_pkg::EV_WDT] = 1'b1;
      state_next.sysRst = 1'b1;
      state_next.cause = wdt_pkg::CAUSE_WDT;
      state_next.pcLoad = 1'b1;
      state_next.firstPending = 1'b1;
    end
    state_next.pc = wdt_pkg::RESET_VECTOR;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);
  assign cpuClkEn = state_reg.mode == wdt_pkg::MODE_RUN;
  assign oscEn = state_reg.mode != wdt_pkg::MODE_STOP;
  assign sysRst = state_reg.sysRst;
  assign resetCause = state_reg.cause;
  assign pcLoad = state_reg.pcLoad;
  assign restartPc = state_reg.pc;
  assign irq = |(state_reg.events & state_reg.mask);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_first_write_taken: assert property (wrCtrl && state_reg.firstPending |=>
      state_reg.ctrl[7:wdt_pkg::LOCK_LO] == $past(pwdata[7:wdt_pkg::LOCK_LO]))
    else $error("Write in the first instruction was not taken.");
  a_upper_locked: assert property (!state_reg.firstPending |=> state_reg.ctrl[7:4] == $past(state_reg.ctrl[7:4]))
    else $error("Locked control bits changed.");
  a_reset_defaults: assert property (disable iff (1'b0) srst |=> state_reg.ctrl == wdt_pkg::CTRL_RESET
      && sysRst && resetCause == wdt_pkg::CAUSE_PIN)
    else $error("Pin reset did not restore the control defaults.");
  a_halt_quiet: assert property (state_reg.mode == wdt_pkg::MODE_HALT && !state_reg.ctrl[wdt_pkg::HALT_RUN_BIT]
      |-> !wd.run ##1 !sysRst)
    else $error("Watchdog ran in HALT while disabled there.");
  a_stop_nop: assert property (stopOp && state_reg.ctrl[wdt_pkg::STOP_DIS_BIT] && !wd.expire |=> cpuClkEn && oscEn)
    else $error("Disabled STOP changed the mode.");
  a_stop_enter: assert property (stopOp && !state_reg.ctrl[wdt_pkg::STOP_DIS_BIT] && !wd.expire
      |=> !oscEn && !cpuClkEn)
    else $error("Enabled STOP did not enter Stop mode.");
  a_wake_rearm: assert property (wakeNow |=> state_reg.ctrl[wdt_pkg::STOP_DIS_BIT] && sysRst
      && resetCause == wdt_pkg::CAUSE_SMR ##1 !sysRst)
    else $error("Stop wakeup did not disable STOP again.");
  a_halt_enter: assert property (haltOp && !wd.expire |=> !cpuClkEn && oscEn)
    else $error("HALT opcode did not gate the CPU clock.");
  a_halt_exit_irq: assert property (state_reg.mode == wdt_pkg::MODE_HALT && irqService |=> cpuClkEn && !pcLoad)
    else $error("Interrupt did not end HALT cleanly.");
  a_timeout_reset: assert property (wd.expire |=> sysRst && pcLoad && restartPc == 16'h0020
      && resetCause == wdt_pkg::CAUSE_WDT && state_reg.ctrl == $past(state_reg.ctrl))
    else $error("Timeout reset wrong or control bits disturbed.");
  a_event_sticky: assert property (state_reg.events[wdt_pkg::EV_WDT] && !(wrEvent && pwdata[wdt_pkg::EV_WDT])
      |=> state_reg.events[wdt_pkg::EV_WDT])
    else $error("Timeout event bit dropped without a clear.");

  c_halt_then_irq: cover property (haltOp ##[1:20] irqService);
  c_stop_wake: cover property (stopOp ##[1:20] wakeNow);
  c_timeout: cover property (wd.expire);
  c_first_write: cover property (wrCtrl && state_reg.firstPending);
endmodule

// ### testbench/watchdog_and_power_down_control_test.sv
// Self-checking testbench for the watchdog and power-down controller.
module watchdog_and_power_down_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // A short base count keeps the timeouts at 16 to 1024 cycles.
  localparam int BASE = 16;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} row_t;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic instrValid = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic irqService = 1'b0;
  logic smrWake = 1'b0;
  logic cpuClkEn;
  logic oscEn;
  logic sysRst;
  logic [1:0] resetCause;
  logic pcLoad;
  logic [15:0] restartPc;
  logic irq;
  int errTotal = 0;
  int nChecks = 0;
  logic [31:0] rd;
  logic er;
  logic f;
  row_t rows [8] = '{
    '{1'b0, 8'h00, 32'h0, 32'hF8, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h21, 1'b0},
    '{1'b1, 8'h10, 32'hFF, 32'h0, 1'b1},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h00, 32'h77, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h70, 1'b0}};

  always #2.5 mclk = ~mclk;

  wdt_power_ctrl #(.BASE_CYCLES(BASE)) wdt_power_ctrl_i (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instrValid(instrValid), .opcode(opcode), .irqService(irqService), .smrWake(smrWake),
    .cpuClkEn(cpuClkEn), .oscEn(oscEn), .sysRst(sysRst), .resetCause(resetCause), .pcLoad(pcLoad),
    .restartPc(restartPc), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic testDone();
    $display("Checks %0d, mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // The slave answer is awaited, never assumed; the watchdog process cuts a hang.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Ends one edge after the instruction is taken so the new mode is visible.
  task automatic instr(input logic [7:0] op);
    @(posedge mclk);
    instrValid <= 1'b1;
    opcode <= op;
    @(posedge mclk);
    instrValid <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic waitRst(input int maxN, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < maxN && !seen; i++)
    begin
      @(posedge mclk);
      seen = (sysRst === 1'b1);
    end
  endtask

  task automatic chkReset(input logic [1:0] cause);
    chk(f, 1'b1);
    chk(resetCause, cause);
    chk(pcLoad, 1'b1);
    chk(restartPc, 16'h0020);
  endtask

  initial
  begin
    #50000;
    errTotal++;
    testDone();
  end

  initial
  begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk({oscEn, cpuClkEn}, 2'h3);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk(er, rows[i].err);
      if (!rows[i].w)
        chk(rd, rows[i].exp);
    end
    instr(8'h00);
    apb(1'b1, 8'h00, 32'h97, rd, er);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk(rd, 32'h70);
    // Select 7 gives 64 base periods, so nothing may fire for 900 cycles.
    waitRst(900, f);
    chk(f, 1'b0);
    waitRst(200, f);
    chkReset(2'h2);
    apb(1'b1, 8'h00, 32'h17, rd, er);
    instr(8'h7F);
    chk({oscEn, cpuClkEn}, 2'h2);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk(rd, 32'h10);
    waitRst(40, f);
    chk(f, 1'b0);
    @(posedge mclk);
    irqService <= 1'b1;
    @(posedge mclk);
    irqService <= 1'b0;
    instr(8'h5F);
    chk(cpuClkEn, 1'b1);
    repeat (4)
    begin
      waitRst(8, f);
      chk(f, 1'b0);
      instr(8'h5F);
    end
    waitRst(10, f);
    chk(f, 1'b0);
    waitRst(20, f);
    chkReset(2'h2);
    apb(1'b1, 8'h00, 32'h00, rd, er);
    instr(8'h6F);
    chk({oscEn, cpuClkEn}, 2'h0);
    @(posedge mclk);
    smrWake <= 1'b1;
    @(posedge mclk);
    smrWake <= 1'b0;
    waitRst(4, f);
    chkReset(2'h1);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk(rd, 32'h08);
    instr(8'h6F);
    chk({oscEn, cpuClkEn}, 2'h3);
    waitRst(100, f);
    chk(f, 1'b0);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    chk(rd, 32'h7);
    chk(irq, 1'b0);
    apb(1'b1, 8'h08, 32'h4, rd, er);
    @(posedge mclk);
    chk(irq, 1'b1);
    apb(1'b1, 8'h04, 32'h4, rd, er);
    @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    chk(rd, 32'h3);
    testDone();
  end
endmodule
